// File: shared/ssg_regs.svh
// Register offsets, field positions, source masks and line codes of the event block
`ifndef SSG_REGS_SVH
`define SSG_REGS_SVH
// How it works
// - Enabled management event with handler flag set clears flag, sends interrupt.
// - Management interrupt leaves as a virtual wire message pulse, no pin.
// - After a message, pending management events wait until flag is set again.
// - Setting the flag with an event still active sends another message at once.
// - Control interrupt is a level held while select is 1 and any enabled control or dual source stays set, or enabled global status stays set.
// - Legacy mode routes control interrupt to line 9, 10 or 11.
// - Advanced mode allows lines 9, 10, 11 and 20 through 23.
// - Polarity inverts when the selected line is shared with a PCI line.
// - Each source has a sticky status bit; only sources outside the no-enable mask have a working enable bit.
// - Pin, bus-0, button, alarm and LAN wake may raise either interrupt.
// - PCIe PME and hot-plug enables gate only the control interrupt.
// - Button override raises only the control interrupt, no enable.
// - Timer overflow, every 2.34 s, raises either type when enabled.
// - Watchdog control message and enabled watchdog control logic raise control only.
// - Watchdog timeout, data-in write, message, mapped NMI raise management only.
// - Intrusion with action field 10 records detection, raises management.
// - Write-enable rising under lock, or write attempt while write-enable is set, sets write status.
// - Firmware release sets global status; OS release raises management if enabled.
// - Port write, periodic timer and 64 ms timer raise management when enabled.
// - USB, serial IRQ, trap, SMBus host and slave raise management only.
// - Global management enable must be 1 for any management interrupt.
// - Control select 1 routes dual sources to control, 0 to management.

// Register byte offsets
`define SSG_STS_OFF     8'h00
`define SSG_EN_OFF      8'h04
`define SSG_CTL_OFF     8'h08
`define SSG_FW_OFF      8'h0C
`define SSG_OUT_OFF     8'h10
// Source bit positions in status and enable words
`define SSG_B_PMPIN     0
`define SSG_B_BUS0      1
`define SSG_B_PCIE      2
`define SSG_B_HOTPLUG   3
`define SSG_B_PWRBTN    4
`define SSG_B_OVERRIDE  5
`define SSG_B_RTC       6
`define SSG_B_TMROF     7
`define SSG_B_LANWAKE   8
`define SSG_B_WDCMSG    9
`define SSG_B_WDCLOG    10
`define SSG_B_WDMLOG    11
`define SSG_B_WDTOUT    12
`define SSG_B_WDDATA    13
`define SSG_B_WDMMSG    14
`define SSG_B_NMI       15
`define SSG_B_INTRUDE   16
`define SSG_B_FWWR      17
`define SSG_B_GLBSTS    18
`define SSG_B_OSREL     19
`define SSG_B_PORT      20
`define SSG_B_PERIODIC  21
`define SSG_B_SWTMR     22
`define SSG_B_USB       23
`define SSG_B_SERIRQ    24
`define SSG_B_TRAP      25
`define SSG_B_SMBHOST   26
`define SSG_B_SMBSLAVE  27
`define SSG_NSRC        28
// Source class masks
`define SSG_DUAL_MASK   28'h00001D3
`define SSG_CTL_ONLY    28'h004062C
`define SSG_MGT_ONLY    28'hFFBF800
`define SSG_NOEN_MASK   28'hB037220
`define SSG_STS_RST     28'h0000000
`define SSG_EN_RST      28'h0000000
// Control word fields
`define SSG_C_EOH       0
`define SSG_C_CSEL      1
`define SSG_C_GMGT      2
`define SSG_C_APIC      3
`define SSG_C_LINE_LO   4
`define SSG_C_LINE_HI   7
`define SSG_C_SHARED    8
`define SSG_C_INTRD_LO  9
`define SSG_C_INTRD_HI  10
`define SSG_CTL_RST     11'h001
`define SSG_INTRD_SMI   2'h2
// Firmware word fields
`define SSG_F_WE        0
`define SSG_F_LOCK      1
`define SSG_F_REL       2
`define SSG_F_GREN      3
`define SSG_F_FWREN     4
// Route line codes
`define SSG_LINE_DEF    4'h9
`define SSG_LINE_MAXL   4'hB
`define SSG_LINE_APMIN  8'h14
`define SSG_LINE_APMAX  8'h17
`endif

// File: shared/ssg_pkg.sv
// Types shared by the event block
`default_nettype none
package ssg_pkg;
    typedef enum logic [0:0] {
        SSG_ARMED = 1'b0,
        SSG_WAIT  = 1'b1
    } ssg_mstate_t;
endpackage
`default_nettype wire

// File: rtl/ssg_event_gen.sv
// Management and control interrupt generator with Wishbone registers
`include "ssg_regs.svh"
`default_nettype none
module ssg_event_gen (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_we_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [`SSG_NSRC-1:0] event_i,
    input  wire logic                 chassis_intrusion_input_i,
    input  wire logic                 fw_write_attempt_i,
    output logic                      virtual_wire_message_o,
    output logic                      ctrl_irq_o,
    output logic      [4:0]           ctrl_irq_line_o
);
    // ************************************************************
    // Bus slave
    // ************************************************************
    logic [`SSG_NSRC-1:0] status;
    logic [`SSG_NSRC-1:0] enable;
    logic [10:0]          ctl;
    logic [4:0]           fw;
    logic                 intr_q;
    ssg_pkg::ssg_mstate_t mstate;
    logic                 req;
    logic                 wr;
    logic                 rd_sts;
    logic [31:0]          wmask;
    logic [31:0]          wdat;
    logic [31:0]          next_rdata;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = req & wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat = wb_dat_i & wmask;

    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wmask) | wdat;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            `SSG_STS_OFF: next_rdata[`SSG_NSRC-1:0] = status;
            `SSG_EN_OFF:  next_rdata[`SSG_NSRC-1:0] = enable;
            `SSG_CTL_OFF: next_rdata[10:0] = ctl;
            `SSG_FW_OFF:  next_rdata[4:0] = fw;
            `SSG_OUT_OFF: next_rdata[6:0] = {ctrl_irq_line_o, ctrl_irq_o,
                                             virtual_wire_message_o};
            default:      next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req & ~wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    // ************************************************************
    // Enables and firmware control
    // ************************************************************
    logic fw_we_rise;
    logic fw_rel_wr;
    logic os_rel_wr;
    logic [31:0] fw_new;
    logic [31:0] en_new;
    assign fw_new = merge({27'h0, fw});
    assign en_new = merge({4'h0, enable});
    assign fw_rel_wr = wr && wb_adr_i == `SSG_FW_OFF
                       && fw_new[`SSG_F_REL];
    assign os_rel_wr = wr && wb_adr_i == `SSG_OUT_OFF
                       && wdat[0];
    assign fw_we_rise = wr && wb_adr_i == `SSG_FW_OFF
                        && fw_new[`SSG_F_WE] && !fw[`SSG_F_WE];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable <= `SSG_EN_RST;
        end else if (wr && wb_adr_i == `SSG_EN_OFF) begin
            enable <= en_new[`SSG_NSRC-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fw <= 5'h00;
        end else if (wr && wb_adr_i == `SSG_FW_OFF) begin
            // Release bit is a strobe, never stored
            fw <= {fw_new[4:3], 1'b0, fw_new[1:0]};
        end
    end

    // ************************************************************
    // Status capture
    // ************************************************************
    logic [`SSG_NSRC-1:0] hw_set;
    logic [`SSG_NSRC-1:0] sw_clr;
    logic                 intr_rise;
    assign intr_rise = chassis_intrusion_input_i & ~intr_q;

    always_comb begin
        hw_set = event_i;
        hw_set[`SSG_B_INTRUDE] = intr_rise &&
            ctl[`SSG_C_INTRD_HI:`SSG_C_INTRD_LO] == `SSG_INTRD_SMI;
        hw_set[`SSG_B_FWWR] = (fw_we_rise && fw[`SSG_F_LOCK])
            || (fw_write_attempt_i && fw[`SSG_F_WE]);
        hw_set[`SSG_B_GLBSTS] = fw_rel_wr;
        hw_set[`SSG_B_OSREL] = os_rel_wr;
    end

    assign sw_clr = (wr && wb_adr_i == `SSG_STS_OFF)
                    ? wdat[`SSG_NSRC-1:0] : `SSG_STS_RST;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intr_q <= 1'b0;
        end else begin
            intr_q <= chassis_intrusion_input_i;
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= `SSG_STS_RST;
        end else begin
            status <= (status & ~sw_clr) | hw_set;
        end
    end

    // ************************************************************
    // Request evaluation
    // ************************************************************
    logic [`SSG_NSRC-1:0] gated;
    logic                 ctl_req;
    logic                 mgt_req;
    logic                 csel;
    assign csel = ctl[`SSG_C_CSEL];
    // Sources with no enable count as always enabled
    assign gated = status & (enable | `SSG_NOEN_MASK);

    always_comb begin
        ctl_req = |(gated & `SSG_CTL_ONLY);
        ctl_req = ctl_req | (csel & |(gated & `SSG_DUAL_MASK));
        // Select gates every control source but global status
        ctl_req = ctl_req & csel;
        // Global status raises the control line even without select
        ctl_req = ctl_req | gated[`SSG_B_GLBSTS];
        mgt_req = |(gated & `SSG_MGT_ONLY
                    & ~(`SSG_NSRC'(1) << `SSG_B_OSREL));
        mgt_req = mgt_req | (status[`SSG_B_OSREL] & fw[`SSG_F_FWREN]);
        mgt_req = mgt_req | (~csel & |(gated & `SSG_DUAL_MASK));
        mgt_req = mgt_req & ctl[`SSG_C_GMGT];
    end

    // ************************************************************
    // Management interrupt sequencing
    // ************************************************************
    logic eoh_wr;
    logic [31:0] ctl_new;
    assign ctl_new = merge({21'h0, ctl});
    assign eoh_wr = wr && wb_adr_i == `SSG_CTL_OFF && ctl_new[`SSG_C_EOH];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl <= `SSG_CTL_RST;
        end else if (mgt_req && ctl[`SSG_C_EOH]) begin
            // Flag clear wins; the other fields still take the write
            if (wr && wb_adr_i == `SSG_CTL_OFF) begin
                ctl <= ctl_new[10:0];
            end
            ctl[`SSG_C_EOH] <= 1'b0;
        end else if (wr && wb_adr_i == `SSG_CTL_OFF) begin
            ctl <= ctl_new[10:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mstate <= ssg_pkg::SSG_ARMED;
        end else begin
            case (mstate)
                ssg_pkg::SSG_ARMED:
                    if (mgt_req && ctl[`SSG_C_EOH]) begin
                        mstate <= ssg_pkg::SSG_WAIT;
                    end
                ssg_pkg::SSG_WAIT:
                    if (eoh_wr) begin
                        mstate <= ssg_pkg::SSG_ARMED;
                    end
                default: mstate <= ssg_pkg::SSG_ARMED;
            endcase
        end
    end

    // One-cycle message pulse replaces a dedicated pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            virtual_wire_message_o <= 1'b0;
        end else begin
            virtual_wire_message_o <= mgt_req && ctl[`SSG_C_EOH];
        end
    end

    // ************************************************************
    // Control interrupt routing
    // ************************************************************
    logic [3:0] line_f;
    logic [4:0] next_line;
    assign line_f = ctl[`SSG_C_LINE_HI:`SSG_C_LINE_LO];

    // Out-of-range codes fall back to the default line
    always_comb begin
        next_line = {1'b0, `SSG_LINE_DEF};
        if (line_f >= `SSG_LINE_DEF && line_f <= `SSG_LINE_MAXL) begin
            next_line = {1'b0, line_f};
        end else if (ctl[`SSG_C_APIC] && {4'h0, line_f} + 8'h10
                     >= `SSG_LINE_APMIN && {4'h0, line_f} + 8'h10
                     <= `SSG_LINE_APMAX) begin
            next_line = 5'({1'b0, line_f} + 5'h10);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_irq_line_o <= {1'b0, `SSG_LINE_DEF};
            ctrl_irq_o      <= 1'b0;
        end else begin
            ctrl_irq_line_o <= next_line;
            // Shared lines run active low
            ctrl_irq_o <= ctl_req ^ ctl[`SSG_C_SHARED];
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_eoh_msg;
        @(posedge clk_i) disable iff (rst_i)
        (mgt_req && ctl[`SSG_C_EOH]) |=> virtual_wire_message_o
            && !ctl[`SSG_C_EOH];
    endproperty
    a_eoh_msg: assert property (p_eoh_msg)
        else $error("handler flag event gave no message");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        !ctl[`SSG_C_EOH] |=> !virtual_wire_message_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("message sent without handler flag");

    sequence s_rearm;
        eoh_wr && mgt_req && mstate == ssg_pkg::SSG_WAIT;
    endsequence
    property p_rearm;
        @(posedge clk_i) disable iff (rst_i)
        s_rearm ##1 mgt_req |=> virtual_wire_message_o;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("rearm did not resend");

    property p_level;
        @(posedge clk_i) disable iff (rst_i)
        ctl_req |=> (ctrl_irq_o != ctl[`SSG_C_SHARED])
            || $past(wr);
    endproperty
    a_level: assert property (p_level)
        else $error("control level not held");

    property p_legacy;
        @(posedge clk_i) disable iff (rst_i)
        !ctl[`SSG_C_APIC] |=> ctrl_irq_line_o <= 5'h0B
            && ctrl_irq_line_o >= 5'h09 || $past(wr);
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy line out of range");

    property p_gmgt;
        @(posedge clk_i) disable iff (rst_i)
        !ctl[`SSG_C_GMGT] |=> !virtual_wire_message_o;
    endproperty
    a_gmgt: assert property (p_gmgt)
        else $error("message with global enable off");

    property p_override;
        @(posedge clk_i) disable iff (rst_i)
        event_i[`SSG_B_OVERRIDE] ##1 ctl[`SSG_C_CSEL]
            |-> status[`SSG_B_OVERRIDE]
            ##1 ((ctrl_irq_o != ctl[`SSG_C_SHARED]) || $past(wr));
    endproperty
    a_override: assert property (p_override)
        else $error("override did not raise control");

    property p_pcie;
        @(posedge clk_i) disable iff (rst_i)
        (gated == (`SSG_NSRC'(1) << `SSG_B_PCIE)) |-> !mgt_req;
    endproperty
    a_pcie: assert property (p_pcie)
        else $error("pcie source reached management");

    property p_glbsts;
        @(posedge clk_i) disable iff (rst_i)
        gated[`SSG_B_GLBSTS] |=> (ctrl_irq_o != ctl[`SSG_C_SHARED])
            || $past(wr);
    endproperty
    a_glbsts: assert property (p_glbsts)
        else $error("global status gave no control level");

    property p_csel_off;
        @(posedge clk_i) disable iff (rst_i)
        !csel && !gated[`SSG_B_GLBSTS] |=> (ctrl_irq_o == ctl[`SSG_C_SHARED])
            || $past(wr);
    endproperty
    a_csel_off: assert property (p_csel_off)
        else $error("control level without select");

    property p_line_set;
        @(posedge clk_i) disable iff (rst_i)
        ctrl_irq_line_o inside {[{1'b0, `SSG_LINE_DEF}:{1'b0, `SSG_LINE_MAXL}],
            [`SSG_LINE_APMIN:`SSG_LINE_APMAX]};
    endproperty
    a_line_set: assert property (p_line_set)
        else $error("control line outside the legal set");

    property p_msg_pulse;
        @(posedge clk_i) disable iff (rst_i)
        virtual_wire_message_o |=> !virtual_wire_message_o;
    endproperty
    a_msg_pulse: assert property (p_msg_pulse)
        else $error("message longer than one cycle");

    property p_wait_flag;
        @(posedge clk_i) disable iff (rst_i)
        mstate == ssg_pkg::SSG_WAIT |-> !ctl[`SSG_C_EOH];
    endproperty
    a_wait_flag: assert property (p_wait_flag)
        else $error("handler flag set while waiting");
endmodule // ssg_event_gen
`default_nettype wire

// File: dv/ssg_host_model.sv
// Host processor model that receives management interrupt messages
`default_nettype none
module ssg_host_model (
    input  wire logic clk_i,
    input  wire logic msg_i,
    input  wire logic ctrl_i,
    output var  int   msg_count_o,
    output var  int   long_msg_o,
    output var  logic ctrl_seen_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic msg_q;
    initial begin
        msg_count_o = 0;
        long_msg_o = 0;
        msg_q = 1'b0;
        ctrl_seen_o = 1'b0;
    end
    // A message is one pulse; a longer one would be taken twice
    always @(posedge clk_i) begin
        if (msg_i === 1'b1)
            msg_count_o <= msg_count_o + 1;
        if (msg_i === 1'b1 && msg_q === 1'b1)
            long_msg_o <= long_msg_o + 1;
        msg_q <= msg_i;
        ctrl_seen_o <= ctrl_i; // Level-mode input
    end
endmodule // ssg_host_model
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench of the interrupt generator
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        int          src;
        logic        en;
        logic [31:0] ctl;
        int          msg;
        logic        lvl;
    } ssg_row_t;
    logic        clk_i = 1'b0;
    logic        rst_i, we, cyc, stb, intr, fwa, ack, msg, ctrl, seen;
    logic [7:0]  adr;
    logic [31:0] dat, rd, q;
    logic [3:0]  sel;
    logic [27:0] ev;
    logic [4:0]  line;
    int          msgc, longc, fails, samples_checked, base;
    ssg_row_t    rows [16] = '{
        '{0, 1, 32'h005, 1, 0}, '{0, 1, 32'h007, 0, 1},
        '{0, 0, 32'h005, 0, 0}, '{2, 1, 32'h005, 0, 0},
        '{3, 1, 32'h007, 0, 1}, '{5, 0, 32'h007, 0, 1},
        '{5, 0, 32'h005, 0, 0}, '{7, 1, 32'h005, 1, 0},
        '{9, 0, 32'h007, 0, 1}, '{10, 1, 32'h007, 0, 1},
        '{12, 0, 32'h005, 1, 0}, '{15, 1, 32'h005, 1, 0},
        '{20, 1, 32'h001, 0, 0}, '{22, 1, 32'h005, 1, 0},
        '{25, 0, 32'h005, 1, 0}, '{0, 1, 32'h103, 0, 1}};
    logic [31:0] lc [9] = '{32'h090, 32'h0A0, 32'h0B0, 32'h0C0, 32'h048,
                            32'h058, 32'h068, 32'h078, 32'h0B8};
    logic [4:0]  le [9] = '{5'h09, 5'h0A, 5'h0B, 5'h09, 5'h14,
                            5'h15, 5'h16, 5'h17, 5'h0B};

    ssg_event_gen dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rd), .wb_ack_o(ack), .event_i(ev),
        .chassis_intrusion_input_i(intr), .fw_write_attempt_i(fwa),
        .virtual_wire_message_o(msg), .ctrl_irq_o(ctrl),
        .ctrl_irq_line_o(line));
    ssg_host_model host (
        .clk_i(clk_i), .msg_i(msg), .ctrl_i(ctrl), .msg_count_o(msgc),
        .long_msg_o(longc), .ctrl_seen_o(seen));

    always #12.5 clk_i = ~clk_i;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic conclude;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; the wait for ack is bounded
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        we <= w;
        dat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                conclude();
            end
            @(posedge clk_i);
        end
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic pulse(input logic [27:0] m);
        ev <= m;
        @(posedge clk_i);
        ev <= 28'h0000000;
    endtask

    task automatic clr;
        wb(8'h00, 1'b1, 32'h0FFFFFFF);
        wb(8'h08, 1'b1, 32'h005);
        base = msgc;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_i = 1'b1;
        {we, cyc, stb, intr, fwa} = 5'h00;
        adr = 8'h00;
        dat = 32'h0;
        sel = 4'hF;
        ev = 28'h0000000;
        fails = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk_i);
        chk({ack, msg, ctrl, line}, 8'h09);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(8'h08, 1'b0, 32'h0);
        chk(q, 32'h001);
        foreach (rows[i]) begin
            wb(8'h04, 1'b1, rows[i].en ? 32'h1 << rows[i].src : 32'h0);
            wb(8'h08, 1'b1, rows[i].ctl);
            base = msgc;
            pulse(28'h1 << rows[i].src);
            repeat (4) @(posedge clk_i);
            chk(msgc - base, rows[i].msg);
            chk(ctrl, rows[i].lvl ^ rows[i].ctl[8]);
            wb(8'h00, 1'b1, 32'h0FFFFFFF);
            wb(8'h04, 1'b1, 32'h0);
            chk(ctrl, {31'h0, rows[i].ctl[8]});
        end
        // Gate on the handler flag, then route line codes
        wb(8'h04, 1'b1, 32'h00100000);
        clr();
        pulse(28'h0100000);
        repeat (3) @(posedge clk_i);
        chk(msgc - base, 1);
        chk(longc, 0);
        wb(8'h08, 1'b0, 32'h0);
        chk(q[0], 0);
        wb(8'h00, 1'b0, 32'h0);
        chk(q[20], 1);
        pulse(28'h0100000);
        repeat (6) @(posedge clk_i);
        chk(msgc - base, 1);
        wb(8'h08, 1'b1, 32'h005);
        repeat (3) @(posedge clk_i);
        chk(msgc - base, 2);
        clr();
        repeat (3) @(posedge clk_i);
        chk(msgc - base, 0);
        foreach (lc[i]) begin
            wb(8'h08, 1'b1, lc[i]);
            repeat (2) @(posedge clk_i);
            chk(line, le[i]);
        end
        // Intrusion and firmware sources
        clr();
        wb(8'h08, 1'b1, 32'h405);
        intr <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(msgc - base, 1);
        wb(8'h00, 1'b0, 32'h0);
        chk(q[16], 1);
        intr <= 1'b0;
        clr();
        wb(8'h0C, 1'b1, 32'h2);
        wb(8'h0C, 1'b1, 32'h3);
        repeat (3) @(posedge clk_i);
        chk(msgc - base, 1);
        wb(8'h00, 1'b0, 32'h0);
        chk(q[17], 1);
        clr();
        fwa <= 1'b1;
        @(posedge clk_i);
        fwa <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(msgc - base, 1);
        wb(8'h0C, 1'b1, 32'h0);
        clr();
        wb(8'h04, 1'b1, 32'h00040000);
        wb(8'h08, 1'b1, 32'h001);
        wb(8'h0C, 1'b1, 32'h4);
        repeat (3) @(posedge clk_i);
        chk(seen, 1);
        wb(8'h00, 1'b0, 32'h0);
        chk(q[18], 1);
        wb(8'h04, 1'b1, 32'h0);
        clr();
        wb(8'h0C, 1'b1, 32'h10);
        wb(8'h10, 1'b1, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(msgc - base, 1);
        wb(8'h20, 1'b1, 32'hFFFFFFFF);
        wb(8'h20, 1'b0, 32'h0);
        chk(q, 32'h0);
        // Reset in mid-run returns every register to its idle value
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({ack, msg, ctrl, line}, 8'h09);
        wb(8'h04, 1'b0, 32'h0);
        chk(q, 32'h0);
        wb(8'h00, 1'b0, 32'h0);
        chk(q, 32'h0);
        wb(8'h08, 1'b0, 32'h0);
        chk(q, 32'h001);
        conclude();
    end
endmodule // tb
`default_nettype wire
